// ===== verilog/dciv_defines.svh
`ifndef DCIV_DEFINES_SVH
`define DCIV_DEFINES_SVH
// clock and time base
`define DCIV_CLK_HZ 10000000
`define DCIV_MS_NS 1000000
`define DCIV_CLK_NS 100
`define DCIV_CYC_PER_MS (`DCIV_MS_NS / `DCIV_CLK_NS)
// monitoring time limits, ms
`define DCIV_MON_MIN_MS 10
`define DCIV_MON_MAX_MS 10000
// discrepancy time limits, ms
`define DCIV_DISC_MIN_MS 10
`define DCIV_DISC_MAX_MS 30000
// short-circuit test timing, ms
`define DCIV_SC_PERIOD_MS 1000
`define DCIV_SC_OFF_MS 1
// diagnostic event bit positions
`define DCIV_EV_DISC 0
`define DCIV_EV_MON 1
`define DCIV_EV_SHORT 2
`define DCIV_EV_W 3
`endif

// ===== verilog/dciv_pkg.sv
package dciv_pkg;
  typedef enum logic [1:0] {
    DCIV_POL_HOLD = 2'h0,
    DCIV_POL_ZERO = 2'h1
  } dciv_policy_e;
  typedef enum logic [1:0] {
    DCIV_IC_ONE = 2'h0,
    DCIV_IC_TWO_EQUIV = 2'h1
  } dciv_icon_e;
  typedef enum logic [1:0] {
    DCIV_SC_IDLE = 2'h0,
    DCIV_SC_OFF = 2'h1,
    DCIV_SC_CHECK = 2'h3
  } dciv_sc_e;
endpackage : dciv_pkg

// ===== verilog/dciv_ms_tick.sv
`timescale 1ns/1ps
`include "dciv_defines.svh"
module dciv_ms_tick #(
  parameter int CYC_PER_MS = `DCIV_CYC_PER_MS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // one-cycle pulse each millisecond
  output logic msTick
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 16'h0001;
    if (cnt_q == 16'(CYC_PER_MS - 1)) begin
      cnt_d = 16'h0000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign msTick = tick_q;
endmodule : dciv_ms_tick

// ===== verilog/dciv_voter.sv
`timescale 1ns/1ps
`include "dciv_defines.svh"
// How it works
// - exchanges with controller watched against monitoring time, 10 to 10000 ms.
// - with module diagnostic enable set, error events raise the interrupt and show.
// - each event source is selected per channel; unselected events stay silent.
// - short-circuit test only works while the module supplies sensor power.
// - short-circuit test briefly switches the module sensor supply off periodically.
// - pair takes part in processing only while activated.
// - one-of-two vote merges both inputs into one delivered signal.
// - interconnection set to two-channel equivalent expects both inputs to agree.
// - hold policy keeps last valid value until agreement or timeout, then error.
// - zero policy delivers 0 immediately on discrepancy, ignoring tolerance time.
// - discrepancy tolerance time per pair, 10 to 30000 ms.
// - disagreement flags discrepancy; error posted only after full tolerance time.
// - integrated safety functions run only in safety mode.
// - with one-of-two vote set, trip delivered when either sensor votes to trip; otherwise sensor A alone decides.
// - logic 1 is normal, logic 0 is a vote to trip.
module dciv_voter #(
  parameter int CYC_PER_MS = `DCIV_CYC_PER_MS,
  parameter int SC_PERIOD_MS = `DCIV_SC_PERIOD_MS,
  parameter int SC_OFF_MS = `DCIV_SC_OFF_MS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // sensor pins, asynchronous
  input wire logic sensorA,
  input wire logic sensorB,
  // configuration
  input wire logic safetyMode,
  input wire logic pairActive,
  input wire logic oneOfTwoVote,
  input wire dciv_pkg::dciv_icon_e sensorWiring,
  input wire dciv_pkg::dciv_policy_e discPolicy,
  input wire logic [14:0] discTimeMs,
  input wire logic [13:0] monTimeMs,
  input wire logic diagEnable,
  input wire logic [`DCIV_EV_W-1:0] diagSelect,
  input wire logic sensorSupplyViaModule,
  input wire logic shortTestEnable,
  // controller exchange
  input wire logic ctrlExchange,
  // outputs
  output logic selectedValue,
  output logic valueValid,
  output logic discrepancy,
  output logic [`DCIV_EV_W-1:0] diagEvents,
  output logic diagInterrupt,
  output logic sensorSupplyOn
);
  logic msTick;
  logic [1:0] syncA_q;
  logic [1:0] syncB_q;
  logic inA;
  logic inB;
  logic run;
  logic [14:0] discMs_q;
  logic [14:0] discMs_d;
  logic discErr_q;
  logic discErr_d;
  logic hold_q;
  logic hold_d;
  logic sel_q;
  logic sel_d;
  logic [13:0] monMs_q;
  logic [13:0] monMs_d;
  logic monErr_q;
  logic monErr_d;
  dciv_pkg::dciv_sc_e sc_q;
  dciv_pkg::dciv_sc_e sc_d;
  logic [15:0] scMs_q;
  logic [15:0] scMs_d;
  logic shortErr_q;
  logic shortErr_d;
  logic [`DCIV_EV_W-1:0] ev_q;
  logic [`DCIV_EV_W-1:0] ev_d;
  logic [`DCIV_EV_W-1:0] raw;
  logic agree;
  logic [14:0] discLim;
  logic [13:0] monLim;

  dciv_ms_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .msTick(msTick)
  );

  // pins pass two flops before anything reads them
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      syncA_q <= 2'h3;
      syncB_q <= 2'h3;
    end else begin
      syncA_q <= {syncA_q[0], sensorA};
      syncB_q <= {syncB_q[0], sensorB};
    end
  end
  assign inA = syncA_q[1];
  assign inB = syncB_q[1];

  assign run = safetyMode & pairActive;
  // single-channel interconnection never reports disagreement
  assign agree = (sensorWiring != dciv_pkg::DCIV_IC_TWO_EQUIV) | (inA == inB);
  // out-of-range settings are clamped rather than refused
  always_comb begin
    discLim = discTimeMs;
    if (discTimeMs < 15'(`DCIV_DISC_MIN_MS)) discLim = 15'(`DCIV_DISC_MIN_MS);
    if (discTimeMs > 15'(`DCIV_DISC_MAX_MS)) discLim = 15'(`DCIV_DISC_MAX_MS);
    monLim = monTimeMs;
    if (monTimeMs < 14'(`DCIV_MON_MIN_MS)) monLim = 14'(`DCIV_MON_MIN_MS);
    if (monTimeMs > 14'(`DCIV_MON_MAX_MS)) monLim = 14'(`DCIV_MON_MAX_MS);
  end

  // voting and discrepancy
  always_comb begin
    discMs_d = discMs_q;
    discErr_d = discErr_q;
    hold_d = hold_q;
    sel_d = sel_q;
    if (!run) begin
      discMs_d = 15'h0000;
      discErr_d = 1'b0;
      hold_d = 1'b0;
      sel_d = 1'b0; // inactive pair delivers the safe trip value
    end else if (agree) begin
      discMs_d = 15'h0000;
      discErr_d = 1'b0;
      hold_d = 1'b0;
      // with one-of-two vote either sensor at 0 trips the result; otherwise sensor A alone decides
      sel_d = oneOfTwoVote ? (inA & inB) : inA;
    end else begin
      if (!hold_q) begin
        hold_d = 1'b1;
      end
      if (discPolicy == dciv_pkg::DCIV_POL_ZERO) begin
        sel_d = 1'b0;
      end else if (discErr_q) begin
        sel_d = 1'b0;
      end else begin
        sel_d = sel_q;
        if (msTick) begin
          discMs_d = discMs_q + 15'h0001;
        end
        // the first tick lands at any phase, so one extra tick keeps the full tolerance
        if (discMs_q > discLim) begin
          discErr_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      discMs_q <= 15'h0000;
      discErr_q <= 1'b0;
      hold_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      discMs_q <= discMs_d;
      discErr_q <= discErr_d;
      hold_q <= hold_d;
      sel_q <= sel_d;
    end
  end

  // controller exchange watchdog
  always_comb begin
    monMs_d = monMs_q;
    monErr_d = monErr_q;
    if (!run || ctrlExchange) begin
      monMs_d = 14'h0000;
      monErr_d = 1'b0;
    end else if (monMs_q > monLim) begin
      monErr_d = 1'b1;
    end else if (msTick) begin
      monMs_d = monMs_q + 14'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      monMs_q <= 14'h0000;
      monErr_q <= 1'b0;
    end else begin
      monMs_q <= monMs_d;
      monErr_q <= monErr_d;
    end
  end

  // short-circuit test: supply off, then a live switch must read 0
  always_comb begin
    sc_d = sc_q;
    scMs_d = scMs_q;
    shortErr_d = shortErr_q;
    if (!(sensorSupplyViaModule && shortTestEnable && run)) begin
      sc_d = dciv_pkg::DCIV_SC_IDLE;
      scMs_d = 16'h0000;
      shortErr_d = 1'b0;
    end else begin
      unique case (sc_q)
        dciv_pkg::DCIV_SC_IDLE: begin
          if (msTick) scMs_d = scMs_q + 16'h0001;
          if (scMs_q >= 16'(SC_PERIOD_MS)) begin
            scMs_d = 16'h0000;
            sc_d = dciv_pkg::DCIV_SC_OFF;
          end
        end
        dciv_pkg::DCIV_SC_OFF: begin
          if (msTick) scMs_d = scMs_q + 16'h0001;
          if (scMs_q >= 16'(SC_OFF_MS)) sc_d = dciv_pkg::DCIV_SC_CHECK;
        end
        dciv_pkg::DCIV_SC_CHECK: begin
          // an input still high with supply cut points to a short to supply
          shortErr_d = inA | inB;
          scMs_d = 16'h0000;
          sc_d = dciv_pkg::DCIV_SC_IDLE;
        end
        default: sc_d = dciv_pkg::DCIV_SC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sc_q <= dciv_pkg::DCIV_SC_IDLE;
      scMs_q <= 16'h0000;
      shortErr_q <= 1'b0;
    end else begin
      sc_q <= sc_d;
      scMs_q <= scMs_d;
      shortErr_q <= shortErr_d;
    end
  end

  // diagnostics
  always_comb begin
    raw = '0;
    raw[`DCIV_EV_DISC] = discErr_q;
    raw[`DCIV_EV_MON] = monErr_q;
    raw[`DCIV_EV_SHORT] = shortErr_q;
    ev_d = (diagEnable && run) ? (raw & diagSelect) : '0;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ev_q <= '0;
    end else begin
      ev_q <= ev_d;
    end
  end

  assign diagEvents = ev_q;
  assign diagInterrupt = |ev_q;
  // unpowered switches read 0 while the supply is cut, so a test shows as a brief trip
  assign selectedValue = sel_q;
  assign valueValid = run & ~discErr_q & ~monErr_q;
  assign discrepancy = hold_q;
  assign sensorSupplyOn = sensorSupplyViaModule & (sc_q != dciv_pkg::DCIV_SC_OFF)
    & (sc_q != dciv_pkg::DCIV_SC_CHECK);
endmodule : dciv_voter

// ===== verification/dciv_voter_monitor.sv
`timescale 1ns/1ps
`include "dciv_defines.svh"
module dciv_voter_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // pins and settings
  input wire logic sensorA,
  input wire logic sensorB,
  input wire logic safetyMode,
  input wire logic pairActive,
  input wire logic oneOfTwoVote,
  input wire dciv_pkg::dciv_icon_e sensorWiring,
  input wire dciv_pkg::dciv_policy_e discPolicy,
  input wire logic diagEnable,
  input wire logic [`DCIV_EV_W-1:0] diagSelect,
  input wire logic sensorSupplyViaModule,
  input wire logic shortTestEnable,
  // results
  input wire logic selectedValue,
  input wire logic valueValid,
  input wire logic discrepancy,
  input wire logic [`DCIV_EV_W-1:0] diagEvents,
  input wire logic diagInterrupt,
  input wire logic sensorSupplyOn
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic run;
  assign run = safetyMode && pairActive;
  property p_irq; diagInterrupt == (|diagEvents); endproperty
  a_irq: assert property (p_irq) else $error("interrupt differs from events");
  property p_off; !diagEnable && !$past(diagEnable) |-> diagEvents == '0; endproperty
  a_off: assert property (p_off) else $error("event while diagnostics off");
  property p_sel; !diagSelect[0] && !$past(diagSelect[0]) |-> !diagEvents[0]; endproperty
  a_sel: assert property (p_sel) else $error("unselected event reported");
  // two idle cycles allowed so a test in flight may wind down
  property p_scno;
    !shortTestEnable && !$past(shortTestEnable, 2) && $stable(sensorSupplyViaModule)
      |-> sensorSupplyOn == sensorSupplyViaModule;
  endproperty
  a_scno: assert property (p_scno) else $error("supply switched without test");
  property p_scoff; $rose(shortTestEnable) && sensorSupplyViaModule |-> ##[1:100] !sensorSupplyOn;
  endproperty
  a_scoff: assert property (p_scoff) else $error("supply never switched off");
  property p_idle; !run |-> !valueValid ##1 !selectedValue; endproperty
  a_idle: assert property (p_idle) else $error("output while not running");
  property p_trip; (!sensorA && !sensorB) [*6] |-> !selectedValue; endproperty
  a_trip: assert property (p_trip) else $error("trip not delivered");
  property p_ok;
    (sensorA && sensorB && run && oneOfTwoVote && !shortTestEnable) [*8] |-> selectedValue;
  endproperty
  a_ok: assert property (p_ok) else $error("normal state not delivered");
  property p_disc;
    (sensorA != sensorB && run && sensorWiring == dciv_pkg::DCIV_IC_TWO_EQUIV) [*4] |-> discrepancy;
  endproperty
  a_disc: assert property (p_disc) else $error("discrepancy not flagged");
  property p_zero;
    discrepancy && discPolicy == dciv_pkg::DCIV_POL_ZERO
      && $past(discPolicy) == dciv_pkg::DCIV_POL_ZERO |-> !selectedValue;
  endproperty
  a_zero: assert property (p_zero) else $error("zero policy not applied");
  property p_wait; $rose(discrepancy) |-> ##1 !diagEvents[0] [*8]; endproperty
  a_wait: assert property (p_wait) else $error("error before tolerance");
  c_err: cover property (discrepancy ##1 diagEvents[0]);
  c_sc: cover property ($fell(sensorSupplyOn));
  c_wd: cover property (diagEvents[1]);
endmodule : dciv_voter_monitor
bind dciv_voter dciv_voter_monitor u_mon (.sys_clk, .reset, .sensorA, .sensorB, .safetyMode,
  .pairActive, .oneOfTwoVote, .sensorWiring, .discPolicy, .diagEnable, .diagSelect,
  .sensorSupplyViaModule, .shortTestEnable, .selectedValue, .valueValid, .discrepancy,
  .diagEvents, .diagInterrupt, .sensorSupplyOn);

// ===== verification/dciv_ctrl_model.sv
`timescale 1ns/1ps
module dciv_ctrl_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // exchange
  input wire logic talk,
  input wire logic selectedValue,
  output logic ctrlExchange,
  output logic seenValue
);
  int cnt = 0;
  // one exchange each 20 cycles, far inside the shortest watchdog time
  always @(posedge sys_clk) begin
    cnt <= (reset || cnt == 19) ? 0 : cnt + 1;
    ctrlExchange <= talk && !reset && cnt == 19;
    if (ctrlExchange) begin
      seenValue <= selectedValue;
    end
  end
endmodule : dciv_ctrl_model

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic sensorA = 1'b1;
  logic sensorB = 1'b1;
  logic safetyMode = 1'b1;
  logic pairActive = 1'b1;
  logic vote = 1'b1;
  dciv_pkg::dciv_icon_e icon = dciv_pkg::DCIV_IC_ONE;
  dciv_pkg::dciv_policy_e pol = dciv_pkg::DCIV_POL_HOLD;
  logic diagEnable = 1'b1;
  logic [2:0] diagSelect = 3'h7;
  logic viaMod = 1'b1;
  logic scTest = 1'b0;
  logic talk = 1'b1;
  // both times set below their minimum on purpose, so the clamp gives 10 ms
  logic [14:0] discTime = 15'h0003;
  logic [13:0] monTime = 14'h0001;
  logic ctrlExchange, selectedValue, valueValid, discrepancy, diagInterrupt, sensorSupplyOn;
  logic seenValue;
  logic [2:0] diagEvents;
  logic [31:0] r;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  int expQ[$];
  dciv_voter #(.CYC_PER_MS(10), .SC_PERIOD_MS(3), .SC_OFF_MS(1)) u_dut (.sys_clk, .reset,
    .sensorA, .sensorB, .safetyMode, .pairActive, .oneOfTwoVote(vote), .sensorWiring(icon),
    .discPolicy(pol), .discTimeMs(discTime), .monTimeMs(monTime), .diagEnable, .diagSelect,
    .sensorSupplyViaModule(viaMod), .shortTestEnable(scTest), .ctrlExchange, .selectedValue,
    .valueValid, .discrepancy, .diagEvents, .diagInterrupt, .sensorSupplyOn);
  dciv_ctrl_model u_ctrl (.sys_clk, .reset, .talk, .selectedValue, .ctrlExchange, .seenValue);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task check(logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task w(int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : w
  task set_b(logic v, int k);
    @(posedge sys_clk);
    sensorB <= v;
    w(k);
  endtask : set_b
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  // the whole sequence needs about 900 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up;
    end
  end
  initial begin
    r = $urandom(54);
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge sys_clk);
      r = $urandom;
      sensorA <= r[0];
      sensorB <= r[1];
      vote <= r[2];
      safetyMode <= r[3] | r[4];
      pairActive <= r[3] | r[5];
      expQ.push_back((r[3] | (r[4] & r[5])) ? (r[2] ? r[0] & r[1] : r[0]) : 0);
      w(8);
      n = expQ.pop_front();
      check(selectedValue, n[0]);
      check(valueValid, r[3] | (r[4] & r[5]));
    end
    $display("vote test done");
    @(posedge sys_clk);
    {sensorA, sensorB, vote, safetyMode, pairActive} <= 5'h1f;
    icon <= dciv_pkg::DCIV_IC_TWO_EQUIV;
    set_b(1'b0, 4);
    check(discrepancy, 1);
    check(selectedValue, 1);
    n = 4;
    while (!diagEvents[0] && n < 200) begin
      w(1);
      n++;
    end
    check(n >= 100 && n <= 125, 1);
    check({selectedValue, valueValid, diagInterrupt}, 3'h1);
    set_b(1'b1, 8);
    check({discrepancy, diagEvents, selectedValue}, 5'h01);
    set_b(1'b0, 60);
    set_b(1'b1, 6);
    set_b(1'b0, 70);
    check(diagEvents[0], 0);
    @(posedge sys_clk);
    diagSelect <= 3'h6;
    w(60);
    check({diagEvents[0], selectedValue}, 0);
    set_b(1'b1, 8);
    @(posedge sys_clk);
    pol <= dciv_pkg::DCIV_POL_ZERO;
    diagSelect <= 3'h7;
    set_b(1'b0, 4);
    check({discrepancy, selectedValue}, 2'h2);
    set_b(1'b1, 8);
    @(posedge sys_clk);
    pol <= dciv_pkg::DCIV_POL_HOLD;
    $display("discrepancy test done");
    talk <= 1'b0;
    w(125);
    check(diagEvents[1], 1);
    @(posedge sys_clk);
    diagEnable <= 1'b0;
    w(2);
    check({diagEvents, diagInterrupt}, 0);
    @(posedge sys_clk);
    diagEnable <= 1'b1;
    talk <= 1'b1;
    w(30);
    check({diagEvents[1], seenValue}, 1);
    $display("watchdog test done");
    @(posedge sys_clk);
    viaMod <= 1'b0;
    scTest <= 1'b1;
    w(80);
    check({sensorSupplyOn, diagEvents[2]}, 0);
    @(posedge sys_clk);
    scTest <= 1'b0;
    viaMod <= 1'b1;
    w(3);
    @(posedge sys_clk);
    scTest <= 1'b1;
    n = 0;
    while (sensorSupplyOn && n < 100) begin
      w(1);
      n++;
    end
    check(n < 100, 1);
    // pins stay high while unpowered, as a shorted switch would
    w(25);
    check(diagEvents[2], 1);
    @(posedge sys_clk);
    scTest <= 1'b0;
    w(3);
    check({diagEvents[2], sensorSupplyOn}, 1);
    $display("short test done");
    wrap_up;
  end
endmodule : tb_top
